//--- rtl/ado_cfg.svh
// Offsets, field positions, reset values and counts of the output control
`ifndef ADO_CFG_SVH
`define ADO_CFG_SVH
`define ADO_WORD_W 14
`define ADO_RAW_W 16
`define ADO_LATENCY 5
`define ADO_CODE_MAX 16'h1fff
`define ADO_CODE_MIN 16'he000
`define ADO_OB_TOP 14'h3fff
`define ADO_OB_BOTTOM 14'h0000
`define ADO_MSB_MASK 14'h2000
`define ADO_OFF_IRQ_STAT 8'h00
`define ADO_OFF_IRQ_MASK 8'h04
`define ADO_OFF_STATE 8'h08
`define ADO_OFF_LAST_A 8'h0c
`define ADO_OFF_LAST_B 8'h10
`define ADO_IRQ_W 4
`define ADO_IRQ_RANGE_A 0
`define ADO_IRQ_RANGE_B 1
`define ADO_IRQ_PWR_A 2
`define ADO_IRQ_PWR_B 3
`define ADO_MASK_RST 4'h0
`define ADO_ST_PWR_A 0
`define ADO_ST_PWR_B 2
`define ADO_ST_TWOS 4
`define ADO_ST_STAB 5
`define ADO_ST_STEER 6
`define ADO_LAST_FLAG 14
`endif

//--- rtl/ado_pkg.sv
// Types and shared decode functions of the output control
package ado_pkg;
  typedef enum logic [1:0] {
    ADO_PWR_NORMAL = 2'b00,
    ADO_PWR_HIGHZ = 2'b01,
    ADO_PWR_NAP = 2'b10,
    ADO_PWR_SLEEP = 2'b11
  } ado_pwr_e;
  typedef enum logic [1:0] {
    ADO_FMT_OB_OFF = 2'b00,
    ADO_FMT_OB_ON = 2'b01,
    ADO_FMT_TC_ON = 2'b10,
    ADO_FMT_TC_OFF = 2'b11
  } ado_fmt_e;
  function automatic ado_pwr_e ado_pwr_of(input logic pd, input logic oe_n);
    case ({pd, oe_n})
      2'b00: ado_pwr_of = ADO_PWR_NORMAL;
      2'b01: ado_pwr_of = ADO_PWR_HIGHZ;
      2'b10: ado_pwr_of = ADO_PWR_NAP;
      2'b11: ado_pwr_of = ADO_PWR_SLEEP;
      default: ado_pwr_of = ADO_PWR_SLEEP;
    endcase
  endfunction
  function automatic logic ado_converting(input ado_pwr_e p);
    ado_converting = (p == ADO_PWR_NORMAL) || (p == ADO_PWR_HIGHZ);
  endfunction
endpackage

//--- rtl/ado_chan.sv
// One converter channel: sample edge, pipeline, format and power state
`include "ado_cfg.svh"
module ado_chan
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic sample_clock_i,
  input wire logic power_down_select_i,
  input wire logic output_enable_n_i,
  input wire logic twos_comp_i,
  input wire logic [`ADO_RAW_W-1:0] sample_i,
  output logic [`ADO_WORD_W-1:0] word_o,
  output logic flag_o,
  output logic new_word_o,
  output logic drive_o,
  output ado_pkg::ado_pwr_e power_o
);
  import ado_pkg::*;
  logic clk_q_reg;
  logic [`ADO_WORD_W-1:0] code_reg [`ADO_LATENCY];
  logic [`ADO_LATENCY-1:0] flag_reg;
  ado_pwr_e power_reg;
  logic rise;
  logic conv;
  logic [`ADO_WORD_W-1:0] in_code;
  logic in_flag;
  assign rise = sample_clock_i & ~clk_q_reg;
  assign conv = rise & ado_converting(power_reg);
  assign power_o = power_reg;
  assign drive_o = (power_reg == ADO_PWR_NORMAL);
  always_comb begin
    in_flag = 1'b0;
    in_code = {~sample_i[`ADO_WORD_W-1], sample_i[`ADO_WORD_W-2:0]};
    if ($signed(sample_i) > $signed(`ADO_CODE_MAX)) begin
      in_flag = 1'b1;
      in_code = `ADO_OB_TOP;
    end else if ($signed(sample_i) < $signed(`ADO_CODE_MIN)) begin
      in_flag = 1'b1;
      in_code = `ADO_OB_BOTTOM;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_q_reg <= 1'b0;
      power_reg <= ADO_PWR_SLEEP;
    end else begin
      clk_q_reg <= sample_clock_i;
      power_reg <= ado_pwr_of(power_down_select_i, output_enable_n_i);
    end
  end
  // Sleep drops the pipeline contents, nap keeps them for a fast restart
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `ADO_LATENCY; i++) begin
        code_reg[i] <= '0;
      end
      flag_reg <= '0;
    end else if (power_reg == ADO_PWR_SLEEP) begin
      for (int i = 0; i < `ADO_LATENCY; i++) begin
        code_reg[i] <= '0;
      end
      flag_reg <= '0;
    end else if (conv) begin
      code_reg[0] <= in_code;
      for (int i = 1; i < `ADO_LATENCY; i++) begin
        code_reg[i] <= code_reg[i-1];
      end
      flag_reg <= {flag_reg[`ADO_LATENCY-2:0], in_flag};
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_o <= '0;
      flag_o <= 1'b0;
      new_word_o <= 1'b0;
    end else begin
      new_word_o <= conv;
      if (conv) begin
        word_o <= twos_comp_i ? code_reg[`ADO_LATENCY-1] ^ `ADO_MSB_MASK
                              : code_reg[`ADO_LATENCY-1];
        flag_o <= flag_reg[`ADO_LATENCY-1];
      end
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_latency_word: assert property (conv |=> word_o ==
    ($past(twos_comp_i) ? $past(code_reg[`ADO_LATENCY-1]) ^ `ADO_MSB_MASK :
    $past(code_reg[`ADO_LATENCY-1])))
    else $error("word did not leave the last pipeline stage");
  a_capture_edge: assert property (!$stable(code_reg[0]) |->
    $past(rise) || $past(power_reg) == ADO_PWR_SLEEP)
    else $error("sample taken without a rising sample clock");
  a_idle_hold: assert property ((power_reg == ADO_PWR_NAP) [*2] |->
    $stable(word_o) && !new_word_o)
    else $error("output word moved while napping");
endmodule

//--- rtl/ado_top.sv
// Dual converter output control with bus steering and register slave
`include "ado_cfg.svh"
module ado_top
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic sample_clock_a_i,
  input wire logic sample_clock_b_i,
  input wire logic bus_steering_select_i,
  input wire logic power_down_select_a_i,
  input wire logic power_down_select_b_i,
  input wire logic output_enable_n_a_i,
  input wire logic output_enable_n_b_i,
  input wire logic [1:0] format_level_i,
  input wire logic [`ADO_RAW_W-1:0] sample_a_i,
  input wire logic [`ADO_RAW_W-1:0] sample_b_i,
  output logic [`ADO_WORD_W-1:0] result_bus_a_o,
  output logic range_flag_a_o,
  output logic result_bus_a_oe_o,
  output logic [`ADO_WORD_W-1:0] result_bus_b_o,
  output logic range_flag_b_o,
  output logic result_bus_b_oe_o,
  output logic stabilizer_on_o,
  output logic irq_o,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);
  import ado_pkg::*;

  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [7:0] off);
    reg_hit = (addr[31:8] == 24'h00_0000) && (addr[7:0] == off);
  endfunction

  // Channel results
  logic [`ADO_WORD_W-1:0] word_a;
  logic [`ADO_WORD_W-1:0] word_b;
  logic flag_a;
  logic flag_b;
  logic new_a;
  logic new_b;
  logic drive_a;
  logic drive_b;
  ado_pwr_e power_a;
  ado_pwr_e power_b;

  // Shared format
  ado_fmt_e fmt_reg;
  logic twos_comp;

  // Event and interrupt state
  ado_pwr_e power_a_q_reg;
  ado_pwr_e power_b_q_reg;
  logic [`ADO_IRQ_W-1:0] events;
  logic [`ADO_IRQ_W-1:0] stat_reg;
  logic [`ADO_IRQ_W-1:0] mask_reg;
  logic [`ADO_WORD_W:0] last_a_reg;
  logic [`ADO_WORD_W:0] last_b_reg;

  // Bus slave state
  logic take;
  logic take_rd;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] rd_value;
  logic stat_rd;

  // Format decode: the level is caught as a two-bit code
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fmt_reg <= ADO_FMT_OB_OFF;
      stabilizer_on_o <= 1'b0;
    end else begin
      fmt_reg <= ado_fmt_e'(format_level_i);
      case (ado_fmt_e'(format_level_i))
        ADO_FMT_OB_OFF: stabilizer_on_o <= 1'b0;
        ADO_FMT_OB_ON: stabilizer_on_o <= 1'b1;
        ADO_FMT_TC_ON: stabilizer_on_o <= 1'b1;
        ADO_FMT_TC_OFF: stabilizer_on_o <= 1'b0;
        default: stabilizer_on_o <= 1'b0;
      endcase
    end
  end

  // One format setting feeds both channels
  assign twos_comp = (fmt_reg == ADO_FMT_TC_ON) ||
                     (fmt_reg == ADO_FMT_TC_OFF);

  // Two independent channels, each with its own clock and power pins
  ado_chan u_chan_a (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .sample_clock_i(sample_clock_a_i),
    .power_down_select_i(power_down_select_a_i),
    .output_enable_n_i(output_enable_n_a_i),
    .twos_comp_i(twos_comp),
    .sample_i(sample_a_i),
    .word_o(word_a),
    .flag_o(flag_a),
    .new_word_o(new_a),
    .drive_o(drive_a),
    .power_o(power_a)
  );

  ado_chan u_chan_b (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .sample_clock_i(sample_clock_b_i),
    .power_down_select_i(power_down_select_b_i),
    .output_enable_n_i(output_enable_n_b_i),
    .twos_comp_i(twos_comp),
    .sample_i(sample_b_i),
    .word_o(word_b),
    .flag_o(flag_b),
    .new_word_o(new_b),
    .drive_o(drive_b),
    .power_o(power_b)
  );

  // Output buses follow steering every cycle; with steering tied to the
  // sample clocks each bus alternates channels with the clock level
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_bus_a_o <= '0;
      range_flag_a_o <= 1'b0;
      result_bus_a_oe_o <= 1'b0;
      result_bus_b_o <= '0;
      range_flag_b_o <= 1'b0;
      result_bus_b_oe_o <= 1'b0;
    end else if (bus_steering_select_i) begin
      result_bus_a_o <= word_a;
      range_flag_a_o <= flag_a;
      result_bus_a_oe_o <= drive_a;
      result_bus_b_o <= word_b;
      range_flag_b_o <= flag_b;
      result_bus_b_oe_o <= drive_b;
    end else begin
      result_bus_a_o <= word_b;
      range_flag_a_o <= flag_b;
      result_bus_a_oe_o <= drive_b;
      result_bus_b_o <= word_a;
      range_flag_b_o <= flag_a;
      result_bus_b_oe_o <= drive_a;
    end
  end

  // Events: a flagged result, or a change of power state
  always_comb begin
    events = '0;
    events[`ADO_IRQ_RANGE_A] = new_a & flag_a;
    events[`ADO_IRQ_RANGE_B] = new_b & flag_b;
    events[`ADO_IRQ_PWR_A] = (power_a != power_a_q_reg);
    events[`ADO_IRQ_PWR_B] = (power_b != power_b_q_reg);
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_a_q_reg <= ADO_PWR_SLEEP;
      power_b_q_reg <= ADO_PWR_SLEEP;
    end else begin
      power_a_q_reg <= power_a;
      power_b_q_reg <= power_b;
    end
  end

  // Last results kept for software, flag above the word
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_a_reg <= '0;
      last_b_reg <= '0;
    end else begin
      if (new_a) begin
        last_a_reg <= {flag_a, word_a};
      end
      if (new_b) begin
        last_b_reg <= {flag_b, word_b};
      end
    end
  end

  // Bus slave: zero wait states, read data registered in address phase
  assign take = hsel_i & htrans_i[1] & hready_i;
  assign take_rd = take & ~hwrite_i;
  assign stat_rd = take_rd & reg_hit(haddr_i, `ADO_OFF_IRQ_STAT);
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_comb begin
    rd_value = '0;
    if (reg_hit(haddr_i, `ADO_OFF_IRQ_STAT)) begin
      rd_value[`ADO_IRQ_W-1:0] = stat_reg;
    end else if (reg_hit(haddr_i, `ADO_OFF_IRQ_MASK)) begin
      rd_value[`ADO_IRQ_W-1:0] = mask_reg;
    end else if (reg_hit(haddr_i, `ADO_OFF_STATE)) begin
      rd_value[`ADO_ST_PWR_A+:2] = power_a;
      rd_value[`ADO_ST_PWR_B+:2] = power_b;
      rd_value[`ADO_ST_TWOS] = twos_comp;
      rd_value[`ADO_ST_STAB] = stabilizer_on_o;
      rd_value[`ADO_ST_STEER] = bus_steering_select_i;
    end else if (reg_hit(haddr_i, `ADO_OFF_LAST_A)) begin
      rd_value[`ADO_LAST_FLAG:0] = last_a_reg;
    end else if (reg_hit(haddr_i, `ADO_OFF_LAST_B)) begin
      rd_value[`ADO_LAST_FLAG:0] = last_b_reg;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= '0;
    end else if (take_rd) begin
      hrdata_o <= rd_value;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= take & hwrite_i;
      if (take) begin
        wr_addr_reg <= haddr_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_reg <= `ADO_MASK_RST;
    end else if (wr_pend_reg && reg_hit(wr_addr_reg, `ADO_OFF_IRQ_MASK)) begin
      mask_reg <= hwdata_i[`ADO_IRQ_W-1:0];
    end
  end

  // Read clears; an event in the same cycle survives the clear
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_reg <= '0;
    end else if (stat_rd) begin
      stat_reg <= events;
    end else begin
      stat_reg <= stat_reg | events;
    end
  end

  assign irq_o = |(stat_reg & mask_reg);

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  a_steer_straight: assert property (bus_steering_select_i |=>
    result_bus_a_o == $past(word_a) && result_bus_b_o == $past(word_b) &&
    range_flag_a_o == $past(flag_a))
    else $error("steering high did not route A to bus A");

  a_steer_swap: assert property (!bus_steering_select_i |=>
    result_bus_a_o == $past(word_b) && result_bus_b_o == $past(word_a) &&
    range_flag_b_o == $past(flag_a))
    else $error("steering low did not swap the buses");

  a_normal_drive: assert property ((!power_down_select_a_i &&
    !output_enable_n_a_i && bus_steering_select_i) [*3] |->
    result_bus_a_oe_o)
    else $error("normal channel A not driving its bus");

  a_highz_convert: assert property ((!power_down_select_b_i &&
    output_enable_n_b_i) [*2] |-> (power_b == ADO_PWR_HIGHZ && !drive_b)
    ##1 (!result_bus_a_oe_o || $past(bus_steering_select_i)))
    else $error("channel B not converting with outputs released");

  a_nap_enter: assert property ((power_down_select_a_i &&
    !output_enable_n_a_i) [*2] |-> power_a == ADO_PWR_NAP && !drive_a)
    else $error("channel A did not nap");

  a_sleep_enter: assert property ((power_down_select_b_i &&
    output_enable_n_b_i) [*2] |-> power_b == ADO_PWR_SLEEP && !drive_b)
    else $error("channel B did not sleep");

  a_sleep_float: assert property (power_b == ADO_PWR_SLEEP &&
    bus_steering_select_i |=> !result_bus_b_oe_o)
    else $error("sleeping channel B still drives its bus");

  a_range_sticky: assert property (new_a && flag_a |=>
    stat_reg[`ADO_IRQ_RANGE_A] ##1 (irq_o || !mask_reg[`ADO_IRQ_RANGE_A]
    || !stat_reg[`ADO_IRQ_RANGE_A]))
    else $error("range event lost from status");

  a_flag_route: assert property (new_b && flag_b &&
    bus_steering_select_i |=> range_flag_b_o)
    else $error("range flag of channel B not on bus B");

  a_read_clear: assert property (stat_rd && events == '0 |=>
    stat_reg == '0 && hrdata_o[`ADO_IRQ_W-1:0] == $past(stat_reg))
    else $error("status read did not return and clear");

  a_power_event: assert property (power_a != power_a_q_reg |=>
    stat_reg[`ADO_IRQ_PWR_A])
    else $error("power change of channel A not recorded");

  a_mask_write: assert property (wr_pend_reg &&
    reg_hit(wr_addr_reg, `ADO_OFF_IRQ_MASK) |=>
    mask_reg == $past(hwdata_i[`ADO_IRQ_W-1:0]))
    else $error("mask write did not land");

  a_format_twos: assert property (format_level_i[1] [*2] |->
    twos_comp && stabilizer_on_o == !$past(format_level_i[0]))
    else $error("format level decoded wrongly");

  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("slave must answer ready and OKAY");

  c_interleave: cover property (bus_steering_select_i ##1
    !bus_steering_select_i ##1 bus_steering_select_i);
  c_nap_with_normal: cover property (power_a == ADO_PWR_NAP &&
    power_b == ADO_PWR_NORMAL);
  c_range_irq: cover property (new_b && flag_b ##2 irq_o);
  c_sleep_wake: cover property (power_a == ADO_PWR_SLEEP ##1
    power_a == ADO_PWR_NORMAL);
  c_highz_b: cover property (power_b == ADO_PWR_HIGHZ);
endmodule

//--- verif/ado_capture.sv
// Downstream capture model: resolves the tristate result buses
`include "ado_cfg.svh"
module ado_capture
(
  input wire logic [`ADO_WORD_W-1:0] word_a_i,
  input wire logic flag_a_i,
  input wire logic oe_a_i,
  input wire logic [`ADO_WORD_W-1:0] word_b_i,
  input wire logic flag_b_i,
  input wire logic oe_b_i,
  output wire [`ADO_WORD_W:0] pins_a_o,
  output wire [`ADO_WORD_W:0] pins_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // No pull on these lines, so a released bus floats rather than holds
  assign pins_a_o = oe_a_i ? {flag_a_i, word_a_i} : {15{1'bz}};
  assign pins_b_o = oe_b_i ? {flag_b_i, word_b_i} : {15{1'bz}};
endmodule

//--- verif/ado_top_tb.sv
// Self-checking bench of the dual converter output control
`include "ado_cfg.svh"
module ado_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b, sclk_a, sclk_b, steer, pd_a, pd_b, oen_a, oen_b;
  logic [1:0] fmt_lvl, htrans;
  logic signed [15:0] samp_a, samp_b;
  logic [13:0] word_a, word_b;
  logic flag_a, flag_b, oe_a, oe_b, stab, irq, hsel, hwrite, hrdy, hresp;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q, q0;
  wire [14:0] pins_a, pins_b;
  int errors = 0;
  int comparisons = 0;
  // Out of range codes early so their flags leave within one stream
  logic signed [15:0] va [10] = '{16'h0000, 16'h2328, 16'hdcd8,
    16'h1fff, 16'he000, 16'h0064, 16'hff9c, 16'h04d2, 16'hef1f, 16'h004d};

  always #5 clk_sys = ~clk_sys;

  ado_top u_dut (.clk_sys_i(clk_sys), .rst_b_i(rst_b),
    .sample_clock_a_i(sclk_a), .sample_clock_b_i(sclk_b),
    .bus_steering_select_i(steer), .power_down_select_a_i(pd_a),
    .power_down_select_b_i(pd_b), .output_enable_n_a_i(oen_a),
    .output_enable_n_b_i(oen_b), .format_level_i(fmt_lvl),
    .sample_a_i(samp_a), .sample_b_i(samp_b), .result_bus_a_o(word_a),
    .range_flag_a_o(flag_a), .result_bus_a_oe_o(oe_a),
    .result_bus_b_o(word_b), .range_flag_b_o(flag_b),
    .result_bus_b_oe_o(oe_b), .stabilizer_on_o(stab), .irq_o(irq),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp));

  ado_capture u_cap (.word_a_i(word_a), .flag_a_i(flag_a), .oe_a_i(oe_a),
    .word_b_i(word_b), .flag_b_i(flag_b), .oe_b_i(oe_b),
    .pins_a_o(pins_a), .pins_b_o(pins_b));

  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Expected bus code: clipped, flagged, top bit flipped for offset binary
  function automatic logic [14:0] fmt(input logic signed [15:0] s,
                                      input logic tc);
    logic signed [15:0] c;
    c = s > 16'sh1fff ? 16'sh1fff : (s < 16'she000 ? 16'she000 : s);
    return {c != s, c[13] ^ ~tc, c[12:0]};
  endfunction

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 64) begin
        errors++;
        $display("BAD %0t bus wait ran out", $time);
        close_out();
      end
      @(posedge clk_sys);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'b010;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0, "resp");
  endtask

  // One sample period is four system clocks, two high and two low
  task automatic stream(input logic st, input logic il, input logic ena,
                        input int n);
    logic tc;
    logic [14:0] ea, eb;
    tc = fmt_lvl[1];
    for (int k = 0; k < n; k++) begin
      @(posedge clk_sys);
      sclk_a <= 1'b1;
      sclk_b <= 1'b1;
      steer <= st | il;
      samp_a <= va[k];
      samp_b <= -va[k];
      repeat (2) @(posedge clk_sys);
      sclk_a <= 1'b0;
      sclk_b <= 1'b0;
      if (il) steer <= 1'b0;
      @(posedge clk_sys);
      #1;
      if (k >= 5 && !il) begin
        ea = fmt(va[k-5], tc);
        eb = fmt(-va[k-5], tc);
        check(pins_a, ena ? (st ? ea : eb) : {15{1'bz}}, "bus a");
        check(pins_b, st ? eb : ea, "bus b");
      end
    end
  endtask

  task automatic t_regs;
    ahb(0, 32'h0000_0004, 0, q);
    check(q, 32'h0000_0000, "mask reset");
    ahb(0, 32'h0000_0020, 0, q);
    check(q, 32'h0000_0000, "unmapped");
    ahb(1, 32'h0000_0008, 32'hffff_ffff, q);
    ahb(0, 32'h0000_0008, 0, q);
    check(q, 32'h0000_0040, "state");
    ahb(0, 32'h0000_0000, 0, q);
    check(q, 32'h0000_000c, "power events");
    $display("test regs done");
  endtask

  task automatic t_path;
    stream(1, 0, 1, 10);
    ahb(0, 32'h0000_000c, 0, q);
    check(q, {17'h0, fmt(va[4], 0)}, "last a");
    check({31'h0, irq}, 32'h0, "irq masked");
    ahb(1, 32'h0000_0004, 32'h0000_0001, q);
    #1;
    check({31'h0, irq}, 32'h1, "irq on");
    ahb(0, 32'h0000_0000, 0, q);
    check(q, 32'h0000_0003, "range status");
    #1;
    check({31'h0, irq}, 32'h0, "irq cleared");
    $display("test path done");
  endtask

  task automatic t_format;
    for (int l = 0; l < 4; l++) begin
      @(posedge clk_sys);
      fmt_lvl <= l[1:0];
      repeat (3) @(posedge clk_sys);
      #1;
      check({31'h0, stab}, {31'h0, l == 1 || l == 2}, "stab");
      ahb(0, 32'h0000_0008, 0, q);
      check({30'h0, q[5:4]}, {30'h0, l == 1 || l == 2, l[1]}, "fmt");
    end
    stream(0, 0, 1, 10);
    $display("test format done");
  endtask

  task automatic t_power;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      steer <= 1'b1;
      pd_a <= i[1];
      oen_a <= i[0];
      repeat (3) @(posedge clk_sys);
      #1;
      check({31'h0, oe_a}, {31'h0, i == 0}, "oe a");
      check({31'h0, oe_b}, 32'h1, "oe b");
      if (i != 0) check(pins_a, {15{1'bz}}, "float a");
      ahb(0, 32'h0000_0008, 0, q);
      check({28'h0, q[3:0]}, i, "power");
    end
    ahb(0, 32'h0000_0000, 0, q);
    check({31'h0, q[2]}, 32'h1, "power event");
    for (int i = 1; i < 4; i++) begin
      pd_b <= i[1];
      oen_b <= i[0];
      repeat (3) @(posedge clk_sys);
      #1;
      check({31'h0, oe_b}, 32'h0, "float b");
      ahb(0, 32'h0000_0008, 0, q);
      check({30'h0, q[3:2]}, i, "power b");
    end
    pd_b <= 1'b0;
    oen_b <= 1'b0;
    $display("test power done");
  endtask

  task automatic t_idle;
    pd_a <= 1'b0;
    oen_a <= 1'b1;
    stream(1, 0, 0, 6);
    ahb(0, 32'h0000_000c, 0, q0);
    check(q0, {17'h0, fmt(va[0], 1)}, "highz converts");
    pd_a <= 1'b1;
    oen_a <= 1'b0;
    stream(1, 0, 0, 8);
    ahb(0, 32'h0000_000c, 0, q);
    check(q, q0, "nap holds");
    pd_a <= 1'b0;
    stream(1, 1, 1, 8);
    ahb(0, 32'h0000_000c, 0, q);
    check(q, {17'h0, fmt(va[2], 1)}, "interleave");
    $display("test idle done");
  endtask

  initial begin
    rst_b = 1'b0;
    {sclk_a, sclk_b, pd_a, pd_b, oen_a, oen_b, hsel, hwrite} = '0;
    steer = 1'b1;
    fmt_lvl = 2'b00;
    samp_a = '0;
    samp_b = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = '0;
    hwdata = '0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_path();
    t_format();
    t_power();
    t_idle();
    close_out();
  end
endmodule
